// >>> hdl/dps_pkg.sv
// shared constants for the dual port streaming ram decode
package dps_pkg;
   localparam int ADDR_W = 17;
   localparam int DATA_W = 8;
   localparam int WORD_W = 9;
   localparam int DEPTH = 131072;
   // bit positions of the pin sample vector
   localparam int PIN_ADDR_LSB = 0;
   localparam int PIN_WE = 17;
   localparam int PIN_CPU_IE = 18;
   localparam int PIN_SYS_IE = 19;
   localparam int PIN_CPU_OE = 20;
   localparam int PIN_BUS_OE = 21;
   localparam int PIN_CPU_LSB = 22;
   localparam int PIN_BUS_LSB = 31;
   localparam int PIN_CLK = 40;
   localparam int PIN_W = 41;
   // reset values
   localparam logic [PIN_W-1:0] PIN_RST = 41'h1ff_ffff_ffff;
   localparam logic [ADDR_W-1:0] ADDR_RST = 17'h0_0000;
   localparam logic [WORD_W-1:0] WORD_RST = 9'h000;
   localparam logic CTRL_RST = 1'b1;
   // cycle kinds, one-hot
   typedef enum logic [5:0] {
      DPS_NOP = 6'b00_0001,
      DPS_READ = 6'b00_0010,
      DPS_WR_CPU = 6'b00_0100,
      DPS_WR_BUS = 6'b00_1000,
      DPS_PASS_CPU = 6'b01_0000,
      DPS_PASS_BUS = 6'b10_0000
   } dps_mode_e;
endpackage

// >>> hdl/dps_word_array.sv
// 128k by 9 storage array with one write and one read port
`timescale 1ns/1ps
module dps_word_array (
   input wire logic clk_in,
   input wire logic wr_en_in,
   input wire logic [dps_pkg::ADDR_W-1:0] wr_addr_in,
   input wire logic [dps_pkg::WORD_W-1:0] wr_data_in,
   input wire logic [dps_pkg::ADDR_W-1:0] rd_addr_in,
   output logic [dps_pkg::WORD_W-1:0] rd_data_out
);
   logic [dps_pkg::WORD_W-1:0] mem [0:dps_pkg::DEPTH-1];

   always_ff @(posedge clk_in) begin
      if (wr_en_in) begin
         mem[wr_addr_in] <= wr_data_in;
      end
      rd_data_out <= mem[rd_addr_in];
   end
endmodule

// >>> hdl/dps_ram_decode.sv
// cycle decode and port logic of the dual port streaming ram
// Functional notes
// - cpu-only read drives cpu port
// - copy-back read drives system port only
// - dual read drives both ports
// - both output enables high: no drive
// - both input enables low: nop, no drive
// - write with no input enable: nop
// - cpu port write into array
// - system port write into array
// - cpu write also streamed to system
// - system write also streamed to cpu
// - cpu data passed to system, no write
// - system data passed to cpu, no write
// - low input enable forces own port off
// - stream data from input register to opposite latch
// - address captured on memory clock fall
// - controls captured on rise, write self-timed
// - port data captured on memory clock rise
// - output latch transparent while clock high
//
// Decided for this implementation: the plain strobed port and the register addresses.
`timescale 1ns/1ps
module dps_ram_decode (
   input wire logic CLK_SYS_IN,
   input wire logic RST_IN,
   input wire logic MEM_CLK_IN,
   input wire logic [dps_pkg::ADDR_W-1:0] ADDR_IN,
   input wire logic WRITE_EN_N_IN,
   input wire logic CPU_SIDE_INPUT_EN_N_IN,
   input wire logic SYS_SIDE_INPUT_EN_N_IN,
   input wire logic CPU_PORT_DRIVE_EN_N_IN,
   input wire logic BUS_PORT_DRIVE_EN_N_IN,
   input wire logic [dps_pkg::DATA_W-1:0] CPU_PORT_DATA_IN,
   input wire logic CPU_PORT_PARITY_IN,
   output logic [dps_pkg::DATA_W-1:0] CPU_PORT_DATA_OUT,
   output logic CPU_PORT_PARITY_OUT,
   output logic CPU_PORT_OE_OUT,
   input wire logic [dps_pkg::DATA_W-1:0] BUS_PORT_DATA_IN,
   input wire logic BUS_PORT_PARITY_IN,
   output logic [dps_pkg::DATA_W-1:0] BUS_PORT_DATA_OUT,
   output logic BUS_PORT_PARITY_OUT,
   output logic BUS_PORT_OE_OUT
);
   // decode of write enable and both input enables
   function automatic dps_pkg::dps_mode_e dps_decode(input logic we_n, input logic cie_n, input logic sie_n);
      dps_pkg::dps_mode_e m;
      m = dps_pkg::DPS_NOP;
      if (!cie_n && !sie_n) begin
         m = dps_pkg::DPS_NOP;
      end else if (cie_n && sie_n) begin
         m = we_n ? dps_pkg::DPS_READ : dps_pkg::DPS_NOP;
      end else if (!cie_n) begin
         m = we_n ? dps_pkg::DPS_PASS_CPU : dps_pkg::DPS_WR_CPU;
      end else begin
         m = we_n ? dps_pkg::DPS_PASS_BUS : dps_pkg::DPS_WR_BUS;
      end
      return m;
   endfunction

   // pin synchronisers
   logic [dps_pkg::PIN_W-1:0] pin_meta;
   logic [dps_pkg::PIN_W-1:0] pin_s;
   logic k_last;
   wire [dps_pkg::PIN_W-1:0] pin_raw = {MEM_CLK_IN, BUS_PORT_PARITY_IN, BUS_PORT_DATA_IN,
      CPU_PORT_PARITY_IN, CPU_PORT_DATA_IN, BUS_PORT_DRIVE_EN_N_IN, CPU_PORT_DRIVE_EN_N_IN,
      SYS_SIDE_INPUT_EN_N_IN, CPU_SIDE_INPUT_EN_N_IN, WRITE_EN_N_IN, ADDR_IN};

   always_ff @(posedge CLK_SYS_IN) begin
      if (RST_IN) begin
         pin_meta <= dps_pkg::PIN_RST;
         pin_s <= dps_pkg::PIN_RST;
         k_last <= dps_pkg::PIN_RST[dps_pkg::PIN_CLK];
      end else begin
         pin_meta <= pin_raw;
         pin_s <= pin_meta;
         k_last <= pin_s[dps_pkg::PIN_CLK];
      end
   end

   // sampled pin fields
   wire k_high = pin_s[dps_pkg::PIN_CLK];
   wire k_rise = k_high && !k_last;
   wire k_fall = !k_high && k_last;
   wire [dps_pkg::ADDR_W-1:0] addr_s = pin_s[dps_pkg::PIN_ADDR_LSB +: dps_pkg::ADDR_W];
   wire we_n_s = pin_s[dps_pkg::PIN_WE];
   wire cie_n_s = pin_s[dps_pkg::PIN_CPU_IE];
   wire sie_n_s = pin_s[dps_pkg::PIN_SYS_IE];
   wire coe_n_s = pin_s[dps_pkg::PIN_CPU_OE];
   wire boe_n_s = pin_s[dps_pkg::PIN_BUS_OE];
   wire [dps_pkg::WORD_W-1:0] cpu_word_s = pin_s[dps_pkg::PIN_CPU_LSB +: dps_pkg::WORD_W];
   wire [dps_pkg::WORD_W-1:0] bus_word_s = pin_s[dps_pkg::PIN_BUS_LSB +: dps_pkg::WORD_W];

   // latched state
   logic [dps_pkg::ADDR_W-1:0] addr_q;
   logic cie_n_q;
   logic sie_n_q;
   logic [dps_pkg::WORD_W-1:0] cpu_in_q;
   logic [dps_pkg::WORD_W-1:0] bus_in_q;
   logic [dps_pkg::WORD_W-1:0] cpu_out_q;
   logic [dps_pkg::WORD_W-1:0] bus_out_q;
   dps_pkg::dps_mode_e mode_q;
   logic [dps_pkg::WORD_W-1:0] rd_data;

   dps_pkg::dps_mode_e next_mode;
   assign next_mode = dps_decode(we_n_s, cie_n_s, sie_n_s);
   wire wr_cpu = k_rise && (next_mode == dps_pkg::DPS_WR_CPU);
   wire wr_bus = k_rise && (next_mode == dps_pkg::DPS_WR_BUS);
   wire wr_en = wr_cpu || wr_bus;
   wire [dps_pkg::WORD_W-1:0] wr_data = wr_cpu ? cpu_word_s : bus_word_s;

   // address on memory clock fall
   always_ff @(posedge CLK_SYS_IN) begin
      if (RST_IN) begin
         addr_q <= dps_pkg::ADDR_RST;
      end else if (k_fall) begin
         addr_q <= addr_s;
      end
   end

   // controls and port data on memory clock rise
   always_ff @(posedge CLK_SYS_IN) begin
      if (RST_IN) begin
         cie_n_q <= dps_pkg::CTRL_RST;
         sie_n_q <= dps_pkg::CTRL_RST;
         cpu_in_q <= dps_pkg::WORD_RST;
         bus_in_q <= dps_pkg::WORD_RST;
         mode_q <= dps_pkg::DPS_NOP;
      end else if (k_rise) begin
         cie_n_q <= cie_n_s;
         sie_n_q <= sie_n_s;
         cpu_in_q <= cpu_word_s;
         bus_in_q <= bus_word_s;
         mode_q <= next_mode;
      end
   end

   dps_word_array u_array (
      .clk_in(CLK_SYS_IN),
      .wr_en_in(wr_en),
      .wr_addr_in(addr_q),
      .wr_data_in(wr_data),
      .rd_addr_in(addr_q),
      .rd_data_out(rd_data)
   );

   // output latch sources: array on reads, opposite input register on streams
   wire cpu_from_bus = (mode_q == dps_pkg::DPS_WR_BUS) || (mode_q == dps_pkg::DPS_PASS_BUS);
   wire bus_from_cpu = (mode_q == dps_pkg::DPS_WR_CPU) || (mode_q == dps_pkg::DPS_PASS_CPU);
   wire [dps_pkg::WORD_W-1:0] next_cpu_out = cpu_from_bus ? bus_in_q : rd_data;
   wire [dps_pkg::WORD_W-1:0] next_bus_out = bus_from_cpu ? cpu_in_q : rd_data;

   always_ff @(posedge CLK_SYS_IN) begin
      if (RST_IN) begin
         cpu_out_q <= dps_pkg::WORD_RST;
         bus_out_q <= dps_pkg::WORD_RST;
      end else if (k_high) begin
         cpu_out_q <= next_cpu_out;
         bus_out_q <= next_bus_out;
      end
   end

   // drivers follow the output enables without waiting for the memory clock
   wire cpu_may_drive = (mode_q == dps_pkg::DPS_READ) || cpu_from_bus;
   wire bus_may_drive = (mode_q == dps_pkg::DPS_READ) || bus_from_cpu;
   assign CPU_PORT_OE_OUT = cpu_may_drive && !coe_n_s && cie_n_q;
   assign BUS_PORT_OE_OUT = bus_may_drive && !boe_n_s && sie_n_q;
   assign CPU_PORT_DATA_OUT = cpu_out_q[dps_pkg::DATA_W-1:0];
   assign CPU_PORT_PARITY_OUT = cpu_out_q[dps_pkg::DATA_W];
   assign BUS_PORT_DATA_OUT = bus_out_q[dps_pkg::DATA_W-1:0];
   assign BUS_PORT_PARITY_OUT = bus_out_q[dps_pkg::DATA_W];

   // checks
   default clocking cb @(posedge CLK_SYS_IN); endclocking
   default disable iff (RST_IN);

   idle_hiz_a: assert property ((coe_n_s && boe_n_s) |-> (!CPU_PORT_OE_OUT && !BUS_PORT_OE_OUT))
      else $error("port driven with both output enables high");

   both_ie_nop_a: assert property ((!cie_n_q && !sie_n_q) |-> (!CPU_PORT_OE_OUT && !BUS_PORT_OE_OUT))
      else $error("port driven with both input enables low");

   write_nop_a: assert property ((k_rise && !we_n_s && cie_n_s && sie_n_s) |-> !wr_en ##1
      (mode_q == dps_pkg::DPS_NOP && !CPU_PORT_OE_OUT && !BUS_PORT_OE_OUT))
      else $error("write enable without input enable did not give nop");

   cpu_write_a: assert property ((k_rise && !we_n_s && !cie_n_s && sie_n_s) |->
      (wr_en && wr_data == cpu_word_s) ##1 (cpu_in_q == $past(cpu_word_s) && !CPU_PORT_OE_OUT
      && BUS_PORT_OE_OUT == !boe_n_s))
      else $error("cpu port write not performed");

   bus_write_a: assert property ((k_rise && !we_n_s && cie_n_s && !sie_n_s) |-> (wr_en && wr_data == bus_word_s))
      else $error("system port write not performed");

   stream_bus_a: assert property ((k_high && bus_from_cpu) |=> (bus_out_q == $past(cpu_in_q)))
      else $error("system latch missed streamed cpu data");

   stream_cpu_a: assert property ((k_high && cpu_from_bus) |=> (cpu_out_q == $past(bus_in_q)))
      else $error("cpu latch missed streamed system data");

   pass_nowrite_a: assert property ((k_rise && we_n_s) |-> !wr_en)
      else $error("array written with write enable high");

   read_cpu_a: assert property ((k_high && mode_q == dps_pkg::DPS_READ) |=> (cpu_out_q == $past(rd_data)
      && bus_out_q == $past(rd_data)))
      else $error("read latch did not take array data");

   ie_force_a: assert property ((!cie_n_q |-> !CPU_PORT_OE_OUT) and (!sie_n_q |-> !BUS_PORT_OE_OUT))
      else $error("port with low input enable is driven");

   read_drive_a: assert property ((mode_q == dps_pkg::DPS_READ && !coe_n_s && !boe_n_s)
      |-> (CPU_PORT_OE_OUT && BUS_PORT_OE_OUT))
      else $error("dual read did not drive both ports");

   addr_fall_a: assert property (k_fall |=> (addr_q == $past(addr_s)) [*1] ##1 $stable(addr_q) or k_fall)
      else $error("address not captured on clock fall");

   latch_hold_a: assert property (!k_high |=> ($stable(cpu_out_q) && $stable(bus_out_q)))
      else $error("output latch changed while clock low");

   cpu_read_only_a: assert property (
      (mode_q == dps_pkg::DPS_READ && !coe_n_s && boe_n_s)
      |-> (CPU_PORT_OE_OUT && !BUS_PORT_OE_OUT))
      else $error("processor read did not drive the cpu port alone");

   copy_back_a: assert property (
      (mode_q == dps_pkg::DPS_READ && coe_n_s && !boe_n_s)
      |-> (!CPU_PORT_OE_OUT && BUS_PORT_OE_OUT))
      else $error("copy back read did not drive the system port alone");

   read_decode_a: assert property (
      (k_rise && we_n_s && cie_n_s && sie_n_s)
      |-> !wr_en ##1 (mode_q == dps_pkg::DPS_READ))
      else $error("read controls not decoded as a read");

   nop_mode_a: assert property (
      (mode_q == dps_pkg::DPS_NOP)
      |-> (!CPU_PORT_OE_OUT && !BUS_PORT_OE_OUT))
      else $error("port driven in a no operation cycle");

   both_ie_mode_a: assert property (
      (k_rise && !cie_n_s && !sie_n_s)
      |-> !wr_en ##1 (mode_q == dps_pkg::DPS_NOP))
      else $error("both input enables low did not give nop");

   cpu_stream_oe_a: assert property (
      (mode_q == dps_pkg::DPS_WR_CPU && !boe_n_s)
      |-> (BUS_PORT_OE_OUT && !CPU_PORT_OE_OUT))
      else $error("write through did not stream to the system port");

   bus_stream_oe_a: assert property (
      (mode_q == dps_pkg::DPS_WR_BUS && !coe_n_s)
      |-> (CPU_PORT_OE_OUT && !BUS_PORT_OE_OUT))
      else $error("allocate did not stream to the cpu port");

   cpu_pass_mode_a: assert property (
      (k_rise && we_n_s && !cie_n_s && sie_n_s)
      |-> !wr_en ##1 (mode_q == dps_pkg::DPS_PASS_CPU))
      else $error("cpu pass through not decoded");

   bus_pass_mode_a: assert property (
      (k_rise && we_n_s && cie_n_s && !sie_n_s)
      |-> !wr_en ##1 (mode_q == dps_pkg::DPS_PASS_BUS))
      else $error("system pass through not decoded");

   cpu_pass_oe_a: assert property (
      (mode_q == dps_pkg::DPS_PASS_CPU && !boe_n_s)
      |-> (BUS_PORT_OE_OUT && !CPU_PORT_OE_OUT))
      else $error("cpu pass through did not drive the system port");

   bus_pass_oe_a: assert property (
      (mode_q == dps_pkg::DPS_PASS_BUS && !coe_n_s)
      |-> (CPU_PORT_OE_OUT && !BUS_PORT_OE_OUT))
      else $error("system pass through did not drive the cpu port");

   write_on_rise_a: assert property (
      wr_en
      |-> k_rise)
      else $error("array written away from a clock rise");

   ctrl_capture_a: assert property (
      k_rise
      |=> (cie_n_q == $past(cie_n_s) && sie_n_q == $past(sie_n_s) && mode_q == $past(next_mode)))
      else $error("controls not captured on clock rise");

   ctrl_hold_a: assert property (
      !k_rise
      |=> ($stable(mode_q) && $stable(cie_n_q) && $stable(sie_n_q)))
      else $error("latched controls changed away from a clock rise");

   mode_onehot_a: assert property (
      $onehot(mode_q))
      else $error("cycle kind is not one-hot");

   cpu_capture_a: assert property (
      (k_rise && !cie_n_s)
      |=> (cpu_in_q == $past(cpu_word_s)))
      else $error("cpu input register missed port data");

   bus_capture_a: assert property (
      (k_rise && !sie_n_s)
      |=> (bus_in_q == $past(bus_word_s)))
      else $error("system input register missed port data");

   addr_hold_a: assert property (
      !k_fall
      |=> $stable(addr_q))
      else $error("address changed away from a clock fall");

   array_write_a: assert property (
      wr_en
      |-> ##2 (rd_data == $past(wr_data, 2)))
      else $error("written word not read back from the array");

endmodule

// >>> dv/dps_far_side.sv
// far side model: cache controller driving the ram pins and both buses
`timescale 1ns/1ps
module dps_far_side (
   input wire logic clk_in,
   input wire logic [dps_pkg::WORD_W-1:0] cpu_word_in,
   input wire logic cpu_oe_in,
   input wire logic [dps_pkg::WORD_W-1:0] bus_word_in,
   input wire logic bus_oe_in,
   output logic mem_clk_out,
   output logic [dps_pkg::ADDR_W-1:0] addr_out,
   output logic [4:0] ctl_n_out,
   output logic [dps_pkg::WORD_W-1:0] cpu_pin_out,
   output logic [dps_pkg::WORD_W-1:0] bus_pin_out
);
   logic [dps_pkg::WORD_W-1:0] cpu_drv = 9'h000;
   logic [dps_pkg::WORD_W-1:0] bus_drv = 9'h000;
   logic [dps_pkg::WORD_W-1:0] cpu_last = 9'h000;
   logic [dps_pkg::WORD_W-1:0] bus_last = 9'h000;
   initial begin
      mem_clk_out = 1'b1;
      addr_out = 17'h0_0000;
      ctl_n_out = 5'h1f;
   end
   // released wire shows the inverse of its last level
   assign cpu_pin_out = cpu_oe_in ? cpu_word_in : (ctl_n_out[3] ? ~cpu_last : cpu_drv);
   assign bus_pin_out = bus_oe_in ? bus_word_in : (ctl_n_out[2] ? ~bus_last : bus_drv);
   always @(posedge clk_in) begin
      if (cpu_oe_in || !ctl_n_out[3]) begin
         cpu_last <= cpu_pin_out;
      end
      if (bus_oe_in || !ctl_n_out[2]) begin
         bus_last <= bus_pin_out;
      end
   end
   // one k cycle: address set before the fall, controls and data held over the rise
   task automatic run(input logic [16:0] a, input logic [4:0] c, input logic [8:0] cw, input logic [8:0] bw);
      @(posedge clk_in);
      addr_out <= a;
      ctl_n_out <= c;
      cpu_drv <= cw;
      bus_drv <= bw;
      repeat (3) @(posedge clk_in);
      mem_clk_out <= 1'b0;
      repeat (6) @(posedge clk_in);
      mem_clk_out <= 1'b1;
      repeat (8) @(posedge clk_in);
   endtask
endmodule

// >>> dv/tb_top.sv
// self-checking bench for the streaming ram decode
`timescale 1ns/1ps
module tb_top;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic mem_clk, cpu_oe, bus_oe, cpu_par, bus_par;
   logic [4:0] ctl_n;
   logic [dps_pkg::ADDR_W-1:0] addr;
   logic [dps_pkg::DATA_W-1:0] cpu_dat, bus_dat;
   logic [dps_pkg::WORD_W-1:0] cpu_pin, bus_pin;
   int miscompares = 0;
   int checked = 0;
   int cycles = 0;
   logic [31:0] seed = 32'h0000_005a;
   logic [8:0] mem [int];
   logic [16:0] slots [4];
   always #2 clk = ~clk;
   dps_far_side dps_far_side_i (.clk_in(clk), .cpu_word_in({cpu_par, cpu_dat}), .cpu_oe_in(cpu_oe),
      .bus_word_in({bus_par, bus_dat}), .bus_oe_in(bus_oe), .mem_clk_out(mem_clk), .addr_out(addr),
      .ctl_n_out(ctl_n), .cpu_pin_out(cpu_pin), .bus_pin_out(bus_pin));
   dps_ram_decode dps_ram_decode_i (.CLK_SYS_IN(clk), .RST_IN(rst), .MEM_CLK_IN(mem_clk), .ADDR_IN(addr),
      .WRITE_EN_N_IN(ctl_n[4]), .CPU_SIDE_INPUT_EN_N_IN(ctl_n[3]), .SYS_SIDE_INPUT_EN_N_IN(ctl_n[2]),
      .CPU_PORT_DRIVE_EN_N_IN(ctl_n[1]), .BUS_PORT_DRIVE_EN_N_IN(ctl_n[0]),
      .CPU_PORT_DATA_IN(cpu_pin[7:0]), .CPU_PORT_PARITY_IN(cpu_pin[8]), .CPU_PORT_DATA_OUT(cpu_dat),
      .CPU_PORT_PARITY_OUT(cpu_par), .CPU_PORT_OE_OUT(cpu_oe), .BUS_PORT_DATA_IN(bus_pin[7:0]),
      .BUS_PORT_PARITY_IN(bus_pin[8]), .BUS_PORT_DATA_OUT(bus_dat), .BUS_PORT_PARITY_OUT(bus_par),
      .BUS_PORT_OE_OUT(bus_oe));
   function automatic logic [31:0] xs(input logic [31:0] x);
      logic [31:0] y;
      y = x ^ (x << 13);
      y = y ^ (y >> 17);
      return y ^ (y << 5);
   endfunction
   // expected drive of {cpu, bus} port from {we_n, cpu_ie_n, sys_ie_n, cpu_oe_n, bus_oe_n}
   function automatic logic [1:0] exp_oe(input logic [4:0] c);
      logic [1:0] r;
      r = {c[3] & ~c[1], c[2] & ~c[0]};
      if (c[3:2] == 2'b00 || c[4:2] == 3'b011) begin
         r = 2'b00;
      end
      return r;
   endfunction
   task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic summarize();
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // one k cycle through the far side, then compare both ports
   task automatic op(input logic [16:0] a, input logic [4:0] c, input logic [8:0] cw, input logic [8:0] bw);
      logic [1:0] eo;
      logic [8:0] rd;
      eo = exp_oe(c);
      rd = mem.exists(a) ? mem[a] : 9'h000;
      dps_far_side_i.run(a, c, cw, bw);
      #1;
      check("cpu_oe", {8'h00, cpu_oe}, {8'h00, eo[1]});
      check("bus_oe", {8'h00, bus_oe}, {8'h00, eo[0]});
      if (eo[1] && (!c[2] || mem.exists(a))) begin
         check("cpu_word", {cpu_par, cpu_dat}, c[2] ? rd : bw);
      end
      if (eo[0] && (!c[3] || mem.exists(a))) begin
         check("bus_word", {bus_par, bus_dat}, c[3] ? rd : cw);
      end
      if (c[4:2] == 3'b001) begin
         mem[a] = cw;
      end
      if (c[4:2] == 3'b010) begin
         mem[a] = bw;
      end
   endtask
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         miscompares++;
         summarize();
      end
   end
   initial begin
      logic [4:0] c;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      #1;
      check("reset_oe", {7'h00, cpu_oe, bus_oe}, 9'h000);
      for (int i = 0; i < 4; i++) begin
         seed = xs(seed);
         slots[i] = (i == 0) ? 17'h1_ffff : seed[16:0];
      end
      for (int i = 0; i < 8; i++) begin
         seed = xs(seed);
         op(slots[i % 4], (i < 4) ? ((i % 2) ? 5'b01001 : 5'b00110) : 5'b11100, seed[8:0], seed[24:16]);
      end
      for (int i = 0; i < 60; i++) begin
         seed = xs(seed);
         c = seed[4:0];
         c[1] = c[1] | ~c[3];
         c[0] = c[0] | ~c[2];
         op(slots[seed[6:5]], c, seed[15:7], seed[24:16]);
      end
      summarize();
   end
endmodule
